// ===== pkg/vcc_pkg.sv
// Register map, field positions and reset values of the comparator control block
package vcc_pkg;
    // ==========================================================
    // Bus and instance geometry
    localparam int unsigned NUM_CMP = 2;
    localparam int unsigned ADR_W   = 10;
    localparam int unsigned DAT_W   = 32;
    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL0  = 8'h9B;
    localparam logic [7:0] IDX_CTRL1  = 8'h9A;
    localparam logic [7:0] IDX_MODE0  = 8'h9D;
    localparam logic [7:0] IDX_MODE1  = 8'h9C;
    localparam logic [7:0] IDX_MUX0   = 8'h9F;
    localparam logic [7:0] IDX_MUX1   = 8'h9E;
    localparam logic [7:0] IDX_RSTSRC = 8'hA0;
    // ==========================================================
    // Control register fields
    localparam int unsigned CTL_EN_BIT   = 7;
    localparam int unsigned CTL_OUT_BIT  = 6;
    localparam int unsigned CTL_RISE_BIT = 5;
    localparam int unsigned CTL_FALL_BIT = 4;
    localparam int unsigned CTL_HYP_HI   = 3;
    localparam int unsigned CTL_HYP_LO   = 2;
    localparam int unsigned CTL_HYN_HI   = 1;
    localparam int unsigned CTL_HYN_LO   = 0;
    // ==========================================================
    // Input mux, response mode and reset source fields
    localparam int unsigned MUX_NEG_HI = 6;
    localparam int unsigned MUX_NEG_LO = 4;
    localparam int unsigned MUX_POS_HI = 2;
    localparam int unsigned MUX_POS_LO = 0;
    localparam int unsigned MODE_HI    = 1;
    localparam int unsigned MODE_LO    = 0;
    localparam int unsigned RSTSRC_BIT = 0;
    // ==========================================================
    // Reset values and writable masks
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] MUX_RST    = 8'h00;
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [7:0] RSTSRC_RST = 8'h00;
    localparam logic [7:0] MUX_MASK   = 8'h77;
    localparam logic [7:0] MODE_MASK  = 8'h03;
endpackage : vcc_pkg

// ===== hdl/vcc_chan.sv
// One comparator channel: result synchroniser, edge detect and sticky edge flags
`timescale 1ns/1ns
module vcc_chan
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic raw_in,
    input  wire logic enable_in,
    input  wire logic clr_rise_in,
    input  wire logic clr_fall_in,
    output logic      latched_out,
    output logic      rise_flag_out,
    output logic      fall_flag_out
);
    // ==========================================================
    // Synchroniser
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise_ev;
    logic fall_ev;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end
        else
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign latched_out = sync2_r;
    // Edges seen while disabled are dropped, so turning off sets no flag
    assign rise_ev = enable_in & sync2_r & ~prev_r;
    assign fall_ev = enable_in & ~sync2_r & prev_r;

    // ==========================================================
    // Sticky flags; a new edge beats a clear in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            rise_flag_out <= 1'b0;
        else if (rise_ev)
            rise_flag_out <= 1'b1;
        else if (clr_rise_in)
            rise_flag_out <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            fall_flag_out <= 1'b0;
        else if (fall_ev)
            fall_flag_out <= 1'b1;
        else if (clr_fall_in)
            fall_flag_out <= 1'b0;
    end

    // ==========================================================
    // Checks
    sync_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(rst_n_in, 3) |-> latched_out == $past(raw_in, 2))
        else $error("latched output not two cycles behind input");
    rise_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rise_ev |=> rise_flag_out)
        else $error("rise flag not set after rising edge");
    fall_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fall_ev |=> fall_flag_out)
        else $error("fall flag not set after falling edge");
    flag_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rise_flag_out && !clr_rise_in |=> rise_flag_out)
        else $error("rise flag dropped without a clear");
    fall_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fall_flag_out && !clr_fall_in |=> fall_flag_out)
        else $error("fall flag dropped without a clear");
endmodule : vcc_chan

// ===== hdl/vcc_top.sv
// Control and status logic for two voltage comparators behind a Wishbone slave
`timescale 1ns/1ns
// Behaviour
// - Two comparator channels share one control scheme and differ only in input choices and reset use.
// - Each channel gives a clock-latched output and a raw output that needs no clock.
// - A per-channel mux register holds positive and negative input selects that drive the pin mux.
// - A disabled comparator drives low on its pin outputs.
// - Each channel can request an interrupt on rising and on falling output edges.
// - A falling edge sets the fall flag and a rising edge sets the rise flag.
// - The flags stay set until software writes them clear, and software must clear them.
// - Bit 6 of the control register reads back the current comparator result.
// - Bit 7 of the control register enables the comparator when one and disables it when zero.
// - Control bits 3-2 set positive and bits 1-0 set negative hysteresis, code 11 meaning 20 mV.
// - A response-mode register per channel selects response time against supply current.
// - Only the first comparator may be chosen as a device reset source.
// - Results can be polled, raised as interrupt requests and routed to pins together.
module vcc_top
    import vcc_pkg::*;
(
    input  wire logic             REF_CLK_IN,
    input  wire logic             RST_N_IN,
    input  wire logic             WB_CYC_IN,
    input  wire logic             WB_STB_IN,
    input  wire logic             WB_WE_IN,
    input  wire logic [ADR_W-1:0] WB_ADR_IN,
    input  wire logic [3:0]       WB_SEL_IN,
    input  wire logic [DAT_W-1:0] WB_DAT_IN,
    output logic                  WB_ACK_OUT,
    output logic      [DAT_W-1:0] WB_DAT_OUT,
    input  wire logic             CMP0_RESULT_IN,
    input  wire logic             CMP1_RESULT_IN,
    output logic                  CMP0_RAW_OUT,
    output logic                  CMP1_RAW_OUT,
    output logic                  CMP0_LATCHED_OUT,
    output logic                  CMP1_LATCHED_OUT,
    output logic                  CMP0_ENABLE_OUT,
    output logic                  CMP1_ENABLE_OUT,
    output logic      [2:0]       CMP0_POS_SELECT_OUT,
    output logic      [2:0]       CMP0_NEG_SELECT_OUT,
    output logic      [2:0]       CMP1_POS_SELECT_OUT,
    output logic      [2:0]       CMP1_NEG_SELECT_OUT,
    output logic      [1:0]       CMP0_POS_HYST_OUT,
    output logic      [1:0]       CMP0_NEG_HYST_OUT,
    output logic      [1:0]       CMP1_POS_HYST_OUT,
    output logic      [1:0]       CMP1_NEG_HYST_OUT,
    output logic      [1:0]       CMP0_MODE_OUT,
    output logic      [1:0]       CMP1_MODE_OUT,
    output logic                  CMP0_RISE_FLAG_OUT,
    output logic                  CMP0_FALL_FLAG_OUT,
    output logic                  CMP1_RISE_FLAG_OUT,
    output logic                  CMP1_FALL_FLAG_OUT,
    output logic                  CMP0_RESET_REQ_OUT
);
    // ==========================================================
    // Index tables per channel
    localparam logic [7:0] IDX_CTRL [NUM_CMP] = '{IDX_CTRL0, IDX_CTRL1};
    localparam logic [7:0] IDX_MUX  [NUM_CMP] = '{IDX_MUX0, IDX_MUX1};
    localparam logic [7:0] IDX_MODE [NUM_CMP] = '{IDX_MODE0, IDX_MODE1};

    logic             ack_r;
    logic [DAT_W-1:0] dat_r;
    logic [7:0]       rd_nxt;
    logic [7:0]       adr_idx;
    logic             req;
    logic             wr_lane;
    logic             rd_req;

    logic [NUM_CMP-1:0] en_r;
    logic [3:0]         hyst_r [NUM_CMP];
    logic [7:0]         mux_r  [NUM_CMP];
    logic [1:0]         mode_r [NUM_CMP];
    logic               rstsrc_r;
    logic               rst_req_r;

    logic [NUM_CMP-1:0] result_in;
    logic [NUM_CMP-1:0] raw_gated;
    logic [NUM_CMP-1:0] lat;
    logic [NUM_CMP-1:0] rise;
    logic [NUM_CMP-1:0] fall;
    logic [NUM_CMP-1:0] wr_ctrl;
    logic [NUM_CMP-1:0] clr_rise;
    logic [NUM_CMP-1:0] clr_fall;

    // ==========================================================
    // Bus request decode
    assign adr_idx = WB_ADR_IN[ADR_W-1:2];
    assign req     = WB_CYC_IN & WB_STB_IN & ~ack_r;
    assign wr_lane = req & WB_WE_IN & WB_SEL_IN[0];
    assign rd_req  = req & ~WB_WE_IN;

    // Single wait state; ack always falls the cycle after it rose
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    // ==========================================================
    // Raw path: gate only, so it follows the analog decision with no clock
    assign result_in = {CMP1_RESULT_IN, CMP0_RESULT_IN};
    assign raw_gated = result_in & en_r;

    // ==========================================================
    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_cmp
            assign wr_ctrl[gi]  = wr_lane & (adr_idx == IDX_CTRL[gi]);
            // Writing zero clears a flag; writing one leaves it alone
            assign clr_rise[gi] = wr_ctrl[gi] & ~WB_DAT_IN[CTL_RISE_BIT];
            assign clr_fall[gi] = wr_ctrl[gi] & ~WB_DAT_IN[CTL_FALL_BIT];

            vcc_chan i_vcc_chan
            (
                .clk_in        (REF_CLK_IN),
                .rst_n_in      (RST_N_IN),
                .raw_in        (raw_gated[gi]),
                .enable_in     (en_r[gi]),
                .clr_rise_in   (clr_rise[gi]),
                .clr_fall_in   (clr_fall[gi]),
                .latched_out   (lat[gi]),
                .rise_flag_out (rise[gi]),
                .fall_flag_out (fall[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Control registers: enable and hysteresis
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                en_r[i]   <= CTRL_RST[CTL_EN_BIT];
                hyst_r[i] <= CTRL_RST[CTL_HYP_HI:CTL_HYN_LO];
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (wr_ctrl[i])
                begin
                    en_r[i]   <= WB_DAT_IN[CTL_EN_BIT];
                    hyst_r[i] <= WB_DAT_IN[CTL_HYP_HI:CTL_HYN_LO];
                end
            end
        end
    end

    // ==========================================================
    // Input mux and response mode registers
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < NUM_CMP; i++)
                mux_r[i] <= MUX_RST;
        end
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (wr_lane && adr_idx == IDX_MUX[i])
                    mux_r[i] <= WB_DAT_IN[7:0] & MUX_MASK;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < NUM_CMP; i++)
                mode_r[i] <= MODE_RST[MODE_HI:MODE_LO];
        end
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                if (wr_lane && adr_idx == IDX_MODE[i])
                    mode_r[i] <= WB_DAT_IN[MODE_HI:MODE_LO];
            end
        end
    end

    // ==========================================================
    // Reset source, first comparator only
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
            rstsrc_r <= RSTSRC_RST[RSTSRC_BIT];
        else if (wr_lane && adr_idx == IDX_RSTSRC)
            rstsrc_r <= WB_DAT_IN[RSTSRC_BIT];
    end

    // Request while selected, enabled and the synchronised result is low
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
            rst_req_r <= 1'b0;
        else
            rst_req_r <= rstsrc_r & en_r[0] & ~lat[0];
    end

    // ==========================================================
    // Read data
    always_comb
    begin
        rd_nxt = 8'h00;
        for (int i = 0; i < NUM_CMP; i++)
        begin
            if (adr_idx == IDX_CTRL[i])
                rd_nxt = {en_r[i], lat[i], rise[i], fall[i], hyst_r[i]};
            if (adr_idx == IDX_MUX[i])
                rd_nxt = mux_r[i];
            if (adr_idx == IDX_MODE[i])
                rd_nxt = {6'h00, mode_r[i]};
        end
        if (adr_idx == IDX_RSTSRC)
            rd_nxt = {7'h00, rstsrc_r};
    end

    // Unmapped reads return zero; unmapped writes are acked and dropped
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_N_IN)
            dat_r <= 32'h0000_0000;
        else if (rd_req)
            dat_r <= {24'h00_0000, rd_nxt};
        else
            dat_r <= 32'h0000_0000;
    end

    // ==========================================================
    // Port map
    assign WB_ACK_OUT          = ack_r;
    assign WB_DAT_OUT          = dat_r;
    assign CMP0_RAW_OUT        = raw_gated[0];
    assign CMP1_RAW_OUT        = raw_gated[1];
    assign CMP0_LATCHED_OUT    = lat[0];
    assign CMP1_LATCHED_OUT    = lat[1];
    assign CMP0_ENABLE_OUT     = en_r[0];
    assign CMP1_ENABLE_OUT     = en_r[1];
    assign CMP0_POS_SELECT_OUT = mux_r[0][MUX_POS_HI:MUX_POS_LO];
    assign CMP0_NEG_SELECT_OUT = mux_r[0][MUX_NEG_HI:MUX_NEG_LO];
    assign CMP1_POS_SELECT_OUT = mux_r[1][MUX_POS_HI:MUX_POS_LO];
    assign CMP1_NEG_SELECT_OUT = mux_r[1][MUX_NEG_HI:MUX_NEG_LO];
    assign CMP0_POS_HYST_OUT   = hyst_r[0][CTL_HYP_HI:CTL_HYP_LO];
    assign CMP0_NEG_HYST_OUT   = hyst_r[0][CTL_HYN_HI:CTL_HYN_LO];
    assign CMP1_POS_HYST_OUT   = hyst_r[1][CTL_HYP_HI:CTL_HYP_LO];
    assign CMP1_NEG_HYST_OUT   = hyst_r[1][CTL_HYN_HI:CTL_HYN_LO];
    assign CMP0_MODE_OUT       = mode_r[0];
    assign CMP1_MODE_OUT       = mode_r[1];
    assign CMP0_RISE_FLAG_OUT  = rise[0];
    assign CMP0_FALL_FLAG_OUT  = fall[0];
    assign CMP1_RISE_FLAG_OUT  = rise[1];
    assign CMP1_FALL_FLAG_OUT  = fall[1];
    assign CMP0_RESET_REQ_OUT  = rst_req_r;

    // ==========================================================
    // Checks
    ack_pulse_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        ack_r |=> !ack_r)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        req |=> ack_r)
        else $error("request not answered next cycle");
    raw_low_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !en_r[0] |-> !CMP0_RAW_OUT)
        else $error("disabled comparator drives its raw output");
    raw1_low_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !en_r[1] |-> !CMP1_RAW_OUT)
        else $error("disabled second comparator drives its raw output");
    lat_low_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        !en_r[0] [*3] |-> !CMP0_LATCHED_OUT)
        else $error("disabled comparator drives latched output");
    state_read_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        rd_req && adr_idx == IDX_CTRL0 |=> WB_DAT_OUT[CTL_OUT_BIT] == $past(lat[0]))
        else $error("output state bit does not match result");
    enable_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        wr_ctrl[1] |=> CMP1_ENABLE_OUT == $past(WB_DAT_IN[CTL_EN_BIT]))
        else $error("enable bit not taken from write");
    hyst_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        wr_ctrl[0] |=> CMP0_POS_HYST_OUT == $past(WB_DAT_IN[3:2])
                    && CMP0_NEG_HYST_OUT == $past(WB_DAT_IN[1:0]))
        else $error("hysteresis fields not taken from write");
    mux_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        wr_lane && adr_idx == IDX_MUX1
        |=> CMP1_NEG_SELECT_OUT == $past(WB_DAT_IN[6:4])
         && CMP1_POS_SELECT_OUT == $past(WB_DAT_IN[2:0]))
        else $error("input select not taken from write");
    mode_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        wr_lane && adr_idx == IDX_MODE0 |=> CMP0_MODE_OUT == $past(WB_DAT_IN[1:0]))
        else $error("response mode not taken from write");
    reset_req_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        ##1 CMP0_RESET_REQ_OUT == $past(rstsrc_r && en_r[0] && !lat[0]))
        else $error("reset request wrong");
    clear_flag_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        $fell(CMP0_RISE_FLAG_OUT) |-> $past(clr_rise[0]))
        else $error("rise flag cleared without a write");
endmodule : vcc_top

// ===== testbench/vcc_analog_model.sv
// Far-side model: analog decisions of both comparators, prompt or delayed
`timescale 1ns/1ns
module vcc_analog_model
(
    input  wire logic       clk_in,
    input  wire logic [1:0] level_in,
    input  wire logic       slow_in,
    output logic            res0_out,
    output logic            res1_out
);
    logic [1:0] dly_r [4];

    // Slow mode mimics a long response setting; its changes land between system edges
    always_ff @(negedge clk_in)
    begin
        dly_r[0] <= level_in;
        for (int i = 1; i < 4; i++)
            dly_r[i] <= dly_r[i-1];
    end

    assign res0_out = slow_in ? dly_r[3][0] : level_in[0];
    assign res1_out = slow_in ? dly_r[3][1] : level_in[1];
endmodule : vcc_analog_model

// ===== testbench/voltage_comparator_control_tb.sv
// Self-checking bench for the comparator control block with a reference model
`timescale 1ns/1ns
module voltage_comparator_control_tb;
    import vcc_pkg::*;
    // ==========================================================
    // Signals
    logic             clk, rst_n, cyc, stb, we, ack, slow, res0, res1, rst_req;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] wdat, rdat, r;
    logic [1:0]       level, raw_w, lat_w, en_w, rf_w, ff_w;
    logic [2:0]       ps_w [2];
    logic [2:0]       ns_w [2];
    logic [1:0]       ph_w [2];
    logic [1:0]       nh_w [2];
    logic [1:0]       md_w [2];
    logic [31:0]      seed = 32'h45;
    int               n_mismatch = 0, samples_checked = 0;
    int               en [2], rf [2], ff [2], hy [2], lv [2];
    logic [7:0]       v;
    localparam logic [7:0] RIDX [7] = '{IDX_CTRL0, IDX_CTRL1, IDX_MODE0, IDX_MODE1,
                                        IDX_MUX0, IDX_MUX1, IDX_RSTSRC};

    vcc_analog_model i_vcc_analog_model (.clk_in(clk), .level_in(level), .slow_in(slow),
        .res0_out(res0), .res1_out(res1));

    vcc_top i_vcc_top (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_ACK_OUT(ack),
        .WB_DAT_OUT(rdat), .CMP0_RESULT_IN(res0), .CMP1_RESULT_IN(res1),
        .CMP0_RAW_OUT(raw_w[0]), .CMP1_RAW_OUT(raw_w[1]), .CMP0_LATCHED_OUT(lat_w[0]),
        .CMP1_LATCHED_OUT(lat_w[1]), .CMP0_ENABLE_OUT(en_w[0]), .CMP1_ENABLE_OUT(en_w[1]),
        .CMP0_POS_SELECT_OUT(ps_w[0]), .CMP0_NEG_SELECT_OUT(ns_w[0]),
        .CMP1_POS_SELECT_OUT(ps_w[1]), .CMP1_NEG_SELECT_OUT(ns_w[1]),
        .CMP0_POS_HYST_OUT(ph_w[0]), .CMP0_NEG_HYST_OUT(nh_w[0]),
        .CMP1_POS_HYST_OUT(ph_w[1]), .CMP1_NEG_HYST_OUT(nh_w[1]),
        .CMP0_MODE_OUT(md_w[0]), .CMP1_MODE_OUT(md_w[1]),
        .CMP0_RISE_FLAG_OUT(rf_w[0]), .CMP0_FALL_FLAG_OUT(ff_w[0]),
        .CMP1_RISE_FLAG_OUT(rf_w[1]), .CMP1_FALL_FLAG_OUT(ff_w[1]),
        .CMP0_RESET_REQ_OUT(rst_req));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // Tasks
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic chk_reg(input logic [31:0] got, input int exp);
        samples_checked++;
        if (got !== 32'(exp))
        begin
            n_mismatch++;
            $display("mismatch at %0t: register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input int exp);
        samples_checked++;
        if (got !== 8'(exp))
        begin
            n_mismatch++;
            $display("mismatch at %0t: port value %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // Request held until ack is sampled high; idle cycle guaranteed by the next call
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
        int k;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20)
        begin
            n_mismatch++;
            $display("mismatch at %0t: no bus acknowledge", $time);
            results();
        end
    endtask : wb

    task automatic wr_ctrl(input int n, input logic [7:0] d);
        wb(1'b1, n ? IDX_CTRL1 : IDX_CTRL0, d, r);
        if (!d[5])
            rf[n] = 0;
        if (!d[4])
            ff[n] = 0;
        if (!en[n] && d[7] && lv[n])
            rf[n] = 1;
        en[n] = d[7];
        hy[n] = d[3:0];
        repeat (6) @(posedge clk);
    endtask : wr_ctrl

    task automatic set_lvl(input int n, input int x);
        if (en[n] && x != lv[n] && x)
            rf[n] = 1;
        if (en[n] && x != lv[n] && !x)
            ff[n] = 1;
        lv[n] = x;
        level[n] <= x[0];
        repeat (12) @(posedge clk);
    endtask : set_lvl

    task automatic check_chan(input int n);
        wb(1'b0, n ? IDX_CTRL1 : IDX_CTRL0, 8'h00, r);
        chk_reg(r, en[n]*128 + (en[n]&lv[n])*64 + rf[n]*32 + ff[n]*16 + hy[n]);
        chk_pin(en_w[n], en[n]);
        chk_pin(raw_w[n], en[n] & lv[n]);
        chk_pin(lat_w[n], en[n] & lv[n]);
        chk_pin(rf_w[n], rf[n]);
        chk_pin(ff_w[n], ff[n]);
        chk_pin(ph_w[n], hy[n] >> 2);
        chk_pin(nh_w[n], hy[n] & 3);
    endtask : check_chan
    // ==========================================================
    // Main sequence
    initial
    begin
        {rst_n, cyc, stb, we, slow} = 5'h00;
        adr = '0;
        sel = 4'hF;
        wdat = '0;
        level = 2'b00;
        r = '0;
        en = '{0, 0};
        rf = '{0, 0};
        ff = '{0, 0};
        hy = '{0, 0};
        lv = '{0, 0};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (RIDX[i])
        begin
            wb(1'b0, RIDX[i], 8'h00, r);
            chk_reg(r, 0);
        end
        wb(1'b1, 8'h10, 8'hFF, r);
        wb(1'b0, 8'h10, 8'h00, r);
        chk_reg(r, 0);
        // A write without the low byte lane must leave the register alone
        sel <= 4'hE;
        wb(1'b1, IDX_MUX0, 8'h77, r);
        sel <= 4'hF;
        wb(1'b0, IDX_MUX0, 8'h00, r);
        chk_reg(r, 0);
        for (int n = 0; n < 2; n++)
        begin
            slow <= n[0];
            v = 8'(xs());
            wb(1'b1, n ? IDX_MUX1 : IDX_MUX0, v, r);
            wb(1'b0, n ? IDX_MUX1 : IDX_MUX0, 8'h00, r);
            chk_reg(r, v & MUX_MASK);
            chk_pin(ps_w[n], v & 8'h07);
            chk_pin(ns_w[n], (v >> 4) & 8'h07);
            v = 8'(xs());
            wb(1'b1, n ? IDX_MODE1 : IDX_MODE0, v, r);
            wb(1'b0, n ? IDX_MODE1 : IDX_MODE0, 8'h00, r);
            chk_reg(r, v & MODE_MASK);
            chk_pin(md_w[n], v & 8'h03);
            v = 8'(xs()) & 8'h0F;
            wr_ctrl(n, 8'h80 | v);
            check_chan(n);
            set_lvl(n, 1);
            check_chan(n);
            wr_ctrl(n, 8'hB0 | v);
            check_chan(n);
            set_lvl(n, 0);
            check_chan(n);
            wr_ctrl(n, 8'h80 | v);
            check_chan(n);
            wr_ctrl(n, v);
            set_lvl(n, 1);
            check_chan(n);
            wr_ctrl(n, 8'h80 | v);
            check_chan(n);
            wr_ctrl(n, v);
            set_lvl(n, 0);
            check_chan(n);
        end
        slow <= 1'b0;
        wb(1'b1, IDX_RSTSRC, 8'h01, r);
        wr_ctrl(0, 8'h80);
        chk_pin(rst_req, 1);
        set_lvl(0, 1);
        chk_pin(rst_req, 0);
        wr_ctrl(1, 8'h80);
        set_lvl(1, 1);
        set_lvl(0, 0);
        chk_pin(rst_req, 1);
        wb(1'b1, IDX_RSTSRC, 8'h00, r);
        repeat (3) @(posedge clk);
        chk_pin(rst_req, 0);
        results();
    end
endmodule : voltage_comparator_control_tb
